// ### core/temp_current_limiter.sv
// Temperature-dependent magnet current limiter with AXI4-Lite registers.
// Assumes aux3 samples arrive from same-clock converter logic; key and switch are pins.
// Function
// - Allowed current is slope times temperature plus intercept, zero above max temperature.
// - Allowed current is compared with the magnitude of the magnet current.
// - Off mode applies no temperature protection except the zero-only rule above max temperature.
// - Entry mode checks a new setpoint only when written, against allowed current.
// - A rejected setpoint beeps once, flags an error, keeps the old target.
// - Continuous mode checks entries and also supervises the running current.
// - Continuous mode ramps excess current down at the system ramp rate.
// - Continuous mode holds a rising ramp at the allowed current.
// - Temperature-limited indication is raised while clamping or ramping down.
// - Above max temperature only a zero setpoint is accepted.
// - Temperature is aux3 volts times scale, then plus offset.
// - Display shows allowed current and temperature, or temperature only when off.
// - An arrow key press toggles the optional display on and off.
// - A hardware switch shows or hides the limit configuration menu.
`timescale 1ns/1ps
module temp_current_limiter
  import temp_limit_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [ADDR_W-1:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [ADDR_W-1:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [DATA_W-1:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  input wire logic signed [DATA_W-1:0] aux3_volt_i,
  input wire logic aux3_valid_i,
  input wire logic arrow_key_i,
  input wire logic menu_switch_i,
  output logic signed [DATA_W-1:0] current_cmd_o,
  output logic temperature_limited_o,
  output logic beep_o,
  output logic irq_o,
  output logic menu_visible_o,
  output logic disp_temp_valid_o,
  output logic disp_allowed_valid_o,
  output logic signed [DATA_W-1:0] disp_temp_o,
  output logic signed [DATA_W-1:0] disp_allowed_o
);
  reg_bus_if bus ();

  prot_mode_t mode;
  logic signed [DATA_W-1:0] limit_slope;
  logic signed [DATA_W-1:0] limit_intercept;
  logic signed [DATA_W-1:0] max_temp;
  logic signed [DATA_W-1:0] temp_scale;
  logic signed [DATA_W-1:0] temp_offset;
  logic [DATA_W-1:0] ramp_rate;
  logic signed [DATA_W-1:0] target;
  logic signed [DATA_W-1:0] temperature;
  logic signed [DATA_W-1:0] line_value;
  logic signed [DATA_W-1:0] allowed_current;
  logic temp_valid;
  logic line_valid;
  logic hot_pending;
  logic above_tmax;
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] irq_mask;
  logic [ST_W-1:0] events;
  logic key_s1, key_s2, key_s3;
  logic sw_s1, sw_s2;
  logic key_press;
  logic display_on;
  logic [DATA_W-1:0] wmask;
  logic signed [DATA_W-1:0] cand;
  logic tgt_wr;
  logic reject;
  logic cfg_wr;
  logic signed [DATA_W-1:0] goal;
  logic signed [DATA_W:0] gap;
  logic over_limit;
  logic next_limited;

  function automatic logic [DATA_W-1:0] mag(input logic signed [DATA_W-1:0] v);
    mag = v[DATA_W-1] ? DATA_W'(-v) : DATA_W'(v);
  endfunction

  axi_lite_port u_port (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .awaddr_i(awaddr_i),
    .awvalid_i(awvalid_i),
    .awready_o(awready_o),
    .wdata_i(wdata_i),
    .wstrb_i(wstrb_i),
    .wvalid_i(wvalid_i),
    .wready_o(wready_o),
    .bresp_o(bresp_o),
    .bvalid_o(bvalid_o),
    .bready_i(bready_i),
    .araddr_i(araddr_i),
    .arvalid_i(arvalid_i),
    .arready_o(arready_o),
    .rdata_o(rdata_o),
    .rresp_o(rresp_o),
    .rvalid_o(rvalid_o),
    .rready_i(rready_i),
    .bus(bus.port_mp)
  );

  // Key and switch are pins, so each passes two flip-flops first.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      {key_s1, key_s2, key_s3} <= 3'h0;
      {sw_s1, sw_s2} <= 2'h0;
    end else begin
      {key_s1, key_s2, key_s3} <= {arrow_key_i, key_s1, key_s2};
      {sw_s1, sw_s2} <= {menu_switch_i, sw_s1};
    end
  end
  assign key_press = key_s2 && !key_s3;
  assign menu_visible_o = sw_s2;

  // Byte lanes merge into the old value; a hidden menu locks the limit setup.
  assign wmask = {{8{bus.wr_strb[3]}}, {8{bus.wr_strb[2]}},
    {8{bus.wr_strb[1]}}, {8{bus.wr_strb[0]}}};
  assign cfg_wr = bus.wr_en && menu_visible_o;
  assign tgt_wr = bus.wr_en && bus.wr_addr == TARGET_OFS;
  assign cand = (target & ~wmask) | (bus.wr_data & wmask);

  // Entry check: zero only when hot, otherwise bounded by allowed current unless mode is off.
  always_comb begin
    reject = 1'b0;
    if (above_tmax && cand != '0) begin
      reject = 1'b1;
    end else if (mode != MODE_OFF && mag(cand) > DATA_W'(allowed_current)) begin
      reject = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      mode <= MODE_OFF;
      limit_slope <= SLOPE_RST;
      limit_intercept <= INTERCEPT_RST;
      max_temp <= MAX_TEMP_RST;
      temp_scale <= T_SCALE_RST;
      temp_offset <= T_OFFSET_RST;
      ramp_rate <= RAMP_RATE_RST;
      irq_mask <= '0;
    end else if (cfg_wr) begin
      unique case (bus.wr_addr)
        CTRL_OFS: begin
          if (bus.wr_strb[0]) begin
            unique case (bus.wr_data[1:0])
              MODE_ENTRY: mode <= MODE_ENTRY;
              MODE_CONT: mode <= MODE_CONT;
              default: mode <= MODE_OFF;
            endcase
          end
        end
        SLOPE_OFS: limit_slope <= (limit_slope & ~wmask) | (bus.wr_data & wmask);
        INTERCEPT_OFS: limit_intercept <= (limit_intercept & ~wmask) | (bus.wr_data & wmask);
        MAX_TEMP_OFS: max_temp <= (max_temp & ~wmask) | (bus.wr_data & wmask);
        T_SCALE_OFS: temp_scale <= (temp_scale & ~wmask) | (bus.wr_data & wmask);
        T_OFFSET_OFS: temp_offset <= (temp_offset & ~wmask) | (bus.wr_data & wmask);
        RAMP_RATE_OFS: ramp_rate <= (ramp_rate & ~wmask) | (bus.wr_data & wmask);
        MASK_OFS: irq_mask <= (irq_mask & ~wmask[ST_W-1:0]) |
          (bus.wr_data[ST_W-1:0] & wmask[ST_W-1:0]);
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      target <= '0;
      beep_o <= 1'b0;
    end else begin
      beep_o <= tgt_wr && reject;
      if (tgt_wr && !reject) begin
        target <= cand;
      end
    end
  end

  always_comb begin
    bus.wr_ok = 1'b1;
    unique case (bus.wr_addr)
      CTRL_OFS, SLOPE_OFS, INTERCEPT_OFS, MAX_TEMP_OFS, T_SCALE_OFS, T_OFFSET_OFS,
      RAMP_RATE_OFS, TARGET_OFS, STATUS_OFS, MASK_OFS, TEMP_OFS, ALLOWED_OFS,
      CURRENT_OFS, STATE_OFS: bus.wr_ok = 1'b1;
      default: bus.wr_ok = 1'b0;
    endcase
  end

  always_comb begin
    bus.rd_ok = 1'b1;
    bus.rd_data = '0;
    unique case (bus.rd_addr)
      CTRL_OFS: bus.rd_data = DATA_W'(mode);
      SLOPE_OFS: bus.rd_data = limit_slope;
      INTERCEPT_OFS: bus.rd_data = limit_intercept;
      MAX_TEMP_OFS: bus.rd_data = max_temp;
      T_SCALE_OFS: bus.rd_data = temp_scale;
      T_OFFSET_OFS: bus.rd_data = temp_offset;
      RAMP_RATE_OFS: bus.rd_data = ramp_rate;
      TARGET_OFS: bus.rd_data = target;
      TEMP_OFS: bus.rd_data = temperature;
      ALLOWED_OFS: bus.rd_data = allowed_current;
      CURRENT_OFS: bus.rd_data = current_cmd_o;
      STATUS_OFS: bus.rd_data = DATA_W'(status);
      MASK_OFS: bus.rd_data = DATA_W'(irq_mask);
      STATE_OFS: bus.rd_data = DATA_W'({menu_visible_o, display_on, above_tmax,
        temperature_limited_o});
      default: bus.rd_ok = 1'b0;
    endcase
  end

  // Two registered stages: volts to kelvin, then kelvin to the limit line.
  fixed_mul_add #(.W(DATA_W), .FRAC(FRAC_W)) u_temp_conv (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .valid_i(aux3_valid_i),
    .a_i(aux3_volt_i),
    .b_i(temp_scale),
    .c_i(temp_offset),
    .valid_o(temp_valid),
    .y_o(temperature)
  );

  fixed_mul_add #(.W(DATA_W), .FRAC(FRAC_W)) u_limit_line (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .valid_i(temp_valid),
    .a_i(limit_slope),
    .b_i(temperature),
    .c_i(limit_intercept),
    .valid_o(line_valid),
    .y_o(line_value)
  );

  // A negative line value cannot be a current bound, so it floors at zero.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      hot_pending <= 1'b0;
      above_tmax <= 1'b0;
      allowed_current <= '0;
    end else begin
      if (temp_valid) begin
        hot_pending <= temperature > max_temp;
      end
      if (line_valid) begin
        above_tmax <= hot_pending;
        allowed_current <= (hot_pending || line_value < 0) ? '0 : line_value;
      end
    end
  end

  // Supervision: the goal is clamped to +/- allowed current in continuous mode.
  always_comb begin
    goal = target;
    if (mode == MODE_CONT) begin
      if (target > allowed_current) begin
        goal = allowed_current;
      end else if (target < -allowed_current) begin
        goal = -allowed_current;
      end
    end
  end
  assign gap = {goal[DATA_W-1], goal} - {current_cmd_o[DATA_W-1], current_cmd_o};
  assign over_limit = mag(current_cmd_o) > DATA_W'(allowed_current);
  assign next_limited = mode == MODE_CONT && (goal != target || over_limit);

  // The current steps by at most the ramp rate each cycle toward the goal.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      current_cmd_o <= '0;
      temperature_limited_o <= 1'b0;
    end else begin
      temperature_limited_o <= next_limited;
      if (gap > $signed({1'b0, ramp_rate})) begin
        current_cmd_o <= current_cmd_o + ramp_rate;
      end else if (-gap > $signed({1'b0, ramp_rate})) begin
        current_cmd_o <= current_cmd_o - ramp_rate;
      end else begin
        current_cmd_o <= goal;
      end
    end
  end

  // Set wins over a write-one clear arriving in the same cycle.
  assign events = {hot_pending && line_valid && !above_tmax,
    next_limited && !temperature_limited_o, tgt_wr && reject};
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      status <= '0;
    end else if (bus.wr_en && bus.wr_addr == STATUS_OFS && bus.wr_strb[0]) begin
      status <= (status & ~bus.wr_data[ST_W-1:0]) | events;
    end else begin
      status <= status | events;
    end
  end
  assign irq_o = |(status & irq_mask);

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      display_on <= 1'b0;
      disp_temp_valid_o <= 1'b0;
      disp_allowed_valid_o <= 1'b0;
      disp_temp_o <= '0;
      disp_allowed_o <= '0;
    end else begin
      if (key_press) begin
        display_on <= !display_on;
      end
      disp_temp_valid_o <= display_on;
      disp_allowed_valid_o <= display_on && mode != MODE_OFF;
      disp_temp_o <= temperature;
      disp_allowed_o <= allowed_current;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  property p_tmax_zero;
    line_valid && hot_pending |=> allowed_current == '0 && above_tmax;
  endproperty
  a_tmax_zero: assert property (p_tmax_zero) else $error("hot limit not zero");

  property p_reject;
    tgt_wr && reject |=> beep_o && status[ST_REJECT] && target == $past(target);
  endproperty
  a_reject: assert property (p_reject) else $error("rejected entry not handled");

  property p_accept;
    tgt_wr && mode == MODE_ENTRY && !above_tmax && mag(cand) <= DATA_W'(allowed_current)
      |=> target == $past(cand) && !beep_o;
  endproperty
  a_accept: assert property (p_accept) else $error("valid entry refused");

  property p_off;
    mode == MODE_OFF |=> !temperature_limited_o;
  endproperty
  a_off: assert property (p_off) else $error("limit active in off mode");

  property p_hot_zero;
    tgt_wr && above_tmax && cand != '0 |=> target == $past(target) && beep_o;
  endproperty
  a_hot_zero: assert property (p_hot_zero) else $error("non-zero entry taken when hot");

  property p_rampdown;
    mode == MODE_CONT && over_limit && ramp_rate != '0 && $stable(allowed_current)
      |=> mag(current_cmd_o) < $past(mag(current_cmd_o));
  endproperty
  a_rampdown: assert property (p_rampdown) else $error("excess current not ramped down");

  property p_hold;
    mode == MODE_CONT && !over_limit && $stable(allowed_current) && !line_valid
      |=> !over_limit;
  endproperty
  a_hold: assert property (p_hold) else $error("current ramped above limit");

  property p_flag;
    mode == MODE_CONT && over_limit |=> temperature_limited_o;
  endproperty
  a_flag: assert property (p_flag) else $error("limited state not shown");

  property p_display;
    key_press |=> display_on != $past(display_on) ##1 disp_allowed_valid_o ==
      (display_on && $past(mode) != MODE_OFF);
  endproperty
  a_display: assert property (p_display) else $error("display toggle wrong");

  property p_recompute;
    temp_valid ##1 line_valid |=> allowed_current == ($past(hot_pending) ? '0 :
      ($past(line_value) < 0 ? '0 : $past(line_value)));
  endproperty
  a_recompute: assert property (p_recompute) else $error("allowed current stale");

  c_reject: cover property (tgt_wr && reject);
  c_rampdown: cover property (mode == MODE_CONT && over_limit ##3 !over_limit);
  c_toggle: cover property (key_press ##[1:100] key_press);
endmodule

// ### inc/temp_limit_pkg.sv
// Shared constants for the temperature-dependent current limiter.
// Assumes Q16.16 signed fixed point for volts, kelvin and amperes.
package temp_limit_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int FRAC_W = 16;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] SLOPE_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] INTERCEPT_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] MAX_TEMP_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] T_SCALE_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] T_OFFSET_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] RAMP_RATE_OFS = 8'h18;
  localparam logic [ADDR_W-1:0] TARGET_OFS = 8'h1c;
  localparam logic [ADDR_W-1:0] TEMP_OFS = 8'h20;
  localparam logic [ADDR_W-1:0] ALLOWED_OFS = 8'h24;
  localparam logic [ADDR_W-1:0] CURRENT_OFS = 8'h28;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h2c;
  localparam logic [ADDR_W-1:0] MASK_OFS = 8'h30;
  localparam logic [ADDR_W-1:0] STATE_OFS = 8'h34;
  localparam logic [DATA_W-1:0] SLOPE_RST = 32'hffea0000;
  localparam logic [DATA_W-1:0] INTERCEPT_RST = 32'h00960000;
  localparam logic [DATA_W-1:0] MAX_TEMP_RST = 32'h00060000;
  localparam logic [DATA_W-1:0] T_SCALE_RST = 32'h00010000;
  localparam logic [DATA_W-1:0] T_OFFSET_RST = 32'h00000000;
  localparam logic [DATA_W-1:0] RAMP_RATE_RST = 32'h00000100;
  localparam int ST_REJECT = 0;
  localparam int ST_LIMIT = 1;
  localparam int ST_HOT = 2;
  localparam int ST_W = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_ENTRY = 2'h1,
    MODE_CONT = 2'h2
  } prot_mode_t;
endpackage

// ### inc/reg_bus_if.sv
// Simple register strobe bus between the AXI4-Lite port and the limiter core.
// Assumes both ends run on one clock; answers to strobes are combinational.
`timescale 1ns/1ps
interface reg_bus_if;
  import temp_limit_pkg::*;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic rd_ok;
  modport port_mp(output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
    input wr_ok, rd_data, rd_ok);
  modport core_mp(input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
    output wr_ok, rd_data, rd_ok);
endinterface

// ### core/fixed_mul_add.sv
// Registered signed fixed-point multiply-add: y = a * b + c.
// Assumes a one-cycle strobe on valid_i; valid_o follows one cycle later.
`timescale 1ns/1ps
module fixed_mul_add
  import temp_limit_pkg::*;
#(
  parameter int W = 32,
  parameter int FRAC = 16
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic valid_i,
  input wire logic signed [W-1:0] a_i,
  input wire logic signed [W-1:0] b_i,
  input wire logic signed [W-1:0] c_i,
  output logic valid_o,
  output logic signed [W-1:0] y_o
);
  logic signed [2*W-1:0] prod;

  assign prod = a_i * b_i;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      valid_o <= 1'b0;
      y_o <= '0;
    end else begin
      valid_o <= valid_i;
      if (valid_i) begin
        y_o <= W'(prod[FRAC +: W] + c_i);
      end
    end
  end
endmodule

// ### core/axi_lite_port.sv
// AXI4-Lite slave front end that turns bus transfers into register strobes.
// Assumes one write and one read under way at a time, as AXI4-Lite allows.
`timescale 1ns/1ps
module axi_lite_port
  import temp_limit_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [ADDR_W-1:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [ADDR_W-1:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [DATA_W-1:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  reg_bus_if.port_mp bus
);
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;

  // Address and data are taken in either order and held until both exist.
  assign awready_o = !aw_held && !bvalid_o;
  assign wready_o = !w_held && !bvalid_o;
  assign bus.wr_en = aw_held && w_held && !bvalid_o;
  assign bus.wr_addr = aw_addr;
  assign arready_o = !rvalid_o;
  assign bus.rd_en = arvalid_i && arready_o;
  assign bus.rd_addr = araddr_i;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      bus.wr_data <= '0;
      bus.wr_strb <= '0;
      bvalid_o <= 1'b0;
      bresp_o <= RESP_OKAY;
    end else begin
      if (awvalid_i && awready_o) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr_i;
      end
      if (wvalid_i && wready_o) begin
        w_held <= 1'b1;
        bus.wr_data <= wdata_i;
        bus.wr_strb <= wstrb_i;
      end
      if (bus.wr_en) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid_o <= 1'b1;
        bresp_o <= bus.wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_o && bready_i) begin
        bvalid_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rvalid_o <= 1'b0;
      rdata_o <= '0;
      rresp_o <= RESP_OKAY;
    end else if (bus.rd_en) begin
      rvalid_o <= 1'b1;
      rdata_o <= bus.rd_data;
      rresp_o <= bus.rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_o && rready_i) begin
      rvalid_o <= 1'b0;
    end
  end
endmodule

// ### dv/temp_source.sv
// Model of the external temperature instrument on auxiliary input 3.
// Assumes it shares the limiter clock and sends one sample per call.
`timescale 1ns/1ps
module temp_source (
  output logic signed [31:0] volt_o,
  output logic valid_o,
  input wire logic clk_i
);
  initial begin
    volt_o = 32'h0;
    valid_o = 1'b0;
  end
  // Between strobes the line shows junk, so a stale read cannot pass.
  task automatic send(input logic [31:0] v);
    @(posedge clk_i);
    volt_o <= v;
    valid_o <= 1'b1;
    @(posedge clk_i);
    volt_o <= ~v;
    valid_o <= 1'b0;
  endtask
endmodule

// ### dv/testbench.sv
// Self-checking bench for the temperature current limiter.
// Assumes one 250 MHz clock and AXI4-Lite register access.
`timescale 1ns/1ps
module testbench;
  import temp_limit_pkg::*;
  logic sys_clk_i, reset_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i;
  logic [7:0] awaddr_i, araddr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [3:0] wstrb_i;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
  logic [1:0] bresp_o, rresp_o;
  logic signed [31:0] aux3_volt_i, current_cmd_o, disp_temp_o, disp_allowed_o;
  logic aux3_valid_i, arrow_key_i, menu_switch_i, temperature_limited_o;
  logic beep_o, irq_o, menu_visible_o, disp_temp_valid_o, disp_allowed_valid_o;
  int fail_count, samples_checked, beeps, b;
  integer seed = 32'h04a5aef6;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  logic [31:0] t;

  temp_current_limiter uut(.sys_clk_i, .reset_i, .awaddr_i, .awvalid_i, .awready_o,
    .wdata_i, .wstrb_i, .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i,
    .araddr_i, .arvalid_i, .arready_o, .rdata_o, .rresp_o, .rvalid_o, .rready_i,
    .aux3_volt_i, .aux3_valid_i, .arrow_key_i, .menu_switch_i, .current_cmd_o,
    .temperature_limited_o, .beep_o, .irq_o, .menu_visible_o, .disp_temp_valid_o,
    .disp_allowed_valid_o, .disp_temp_o, .disp_allowed_o);
  temp_source src(.volt_o(aux3_volt_i), .valid_o(aux3_valid_i), .clk_i(sys_clk_i));

  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic tick(input int i);
    @(posedge sys_clk_i);
    if (i > 3000) begin
      fail_count++;
      $display("[ERR] %0t wait ran out", $time);
      results();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    awaddr_i <= a;
    wdata_i <= d;
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b1;
    for (int i = 0; !(bvalid_o === 1'b1 && bready_i); i++) begin
      tick(i);
      if (awvalid_i && awready_o) awvalid_i <= 1'b0;
      if (wvalid_i && wready_o) wvalid_i <= 1'b0;
    end
    bready_i <= 1'b0;
    chk({30'h0, bresp_o}, {30'h0, RESP_OKAY});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({r, d});
    @(posedge sys_clk_i);
    araddr_i <= a;
    arvalid_i <= 1'b1;
    rready_i <= 1'b1;
    for (int i = 0; !(rvalid_o === 1'b1 && rready_i); i++) begin
      tick(i);
      if (arvalid_i && arready_o) arvalid_i <= 1'b0;
    end
    rready_i <= 1'b0;
  endtask

  task automatic wait_cur(input logic [31:0] v);
    for (int i = 0; current_cmd_o !== v; i++) tick(i);
  endtask

  task automatic bad_target(input logic [31:0] v);
    b = beeps;
    wr(TARGET_OFS, v);
    repeat (3) @(posedge sys_clk_i);
    chk(beeps - b, 1);
  endtask

  task automatic press();
    arrow_key_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    arrow_key_i <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
  endtask

  // Read results are compared here in issue order.
  always @(posedge sys_clk_i) begin
    if (rvalid_o === 1'b1 && rready_i) begin
      e = exp_q.pop_front();
      chk(rdata_o, e[31:0]);
      chk({30'h0, rresp_o}, {30'h0, e[33:32]});
    end
    if (beep_o === 1'b1) beeps++;
  end

  initial begin
    {awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i, arrow_key_i} = 6'h0;
    {awaddr_i, araddr_i, wdata_i} = 48'h0;
    wstrb_i = 4'hf;
    menu_switch_i = 1'b0;
    reset_i = 1'b1;
    repeat (10) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    rd(8'hfc, 32'h0, RESP_SLVERR);
    wr(SLOPE_OFS, 32'h0);
    rd(SLOPE_OFS, SLOPE_RST, RESP_OKAY);
    menu_switch_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    chk(menu_visible_o, 1);
    $display("menu test done");
    wr(T_SCALE_OFS, 32'h00020000);
    wr(T_OFFSET_OFS, 32'h00010000);
    wr(RAMP_RATE_OFS, 32'h00010000);
    // Random volts 0..3 give 1..7 K, which straddles the hot threshold.
    repeat (6) begin
      t = $random(seed) & 32'h3;
      src.send(t << 16);
      repeat (6) @(posedge sys_clk_i);
      t = 2 * t + 1;
      rd(TEMP_OFS, t << 16, RESP_OKAY);
      rd(ALLOWED_OFS, (t > 6) ? 0 : (150 - 22 * t) << 16, RESP_OKAY);
    end
    src.send(32'h00020000);
    repeat (6) @(posedge sys_clk_i);
    $display("conversion test done");
    wr(CTRL_OFS, 32'h1);
    wr(MASK_OFS, 32'h1);
    bad_target(32'h00320000);
    chk(irq_o, 1);
    bad_target(32'hffce0000);
    rd(TARGET_OFS, 32'h0, RESP_OKAY);
    wr(STATUS_OFS, 32'h1);
    chk(irq_o, 0);
    wr(TARGET_OFS, 32'h00280000);
    rd(TARGET_OFS, 32'h00280000, RESP_OKAY);
    press();
    chk(disp_allowed_valid_o, 1);
    chk(disp_allowed_o, 32'h00280000);
    chk(disp_temp_o, 32'h00050000);
    press();
    chk(disp_temp_valid_o, 0);
    $display("entry test done");
    wr(CTRL_OFS, 32'h2);
    wait_cur(32'h00280000);
    src.send(32'h00028000);
    wait_cur(32'h00120000);
    repeat (4) @(posedge sys_clk_i);
    chk(current_cmd_o, 32'h00120000);
    chk(temperature_limited_o, 1);
    bad_target(32'h00140000);
    src.send(32'h00030000);
    wait_cur(32'h0);
    bad_target(32'h00010000);
    rd(STATUS_OFS, 32'h7, RESP_OKAY);
    $display("continuous test done");
    wr(CTRL_OFS, 32'h0);
    src.send(32'h00020000);
    repeat (6) @(posedge sys_clk_i);
    press();
    chk(disp_temp_valid_o, 1);
    chk(disp_allowed_valid_o, 0);
    wr(TARGET_OFS, 32'h00640000);
    wait_cur(32'h00640000);
    chk(temperature_limited_o, 0);
    $display("off test done");
    results();
  end
endmodule
